// ### logic/irq_arbiter.sv
// gating, level forming and fixed-order selection of interrupt sources
// assumes vectors ordered by polling rank, lowest index wins a tie
`timescale 1ns/10ps
module irq_arbiter #(parameter int N = 11, parameter int IW = 4) (
    src_if.arb sif
);
    // ==========================================
    // effective requests and levels
    always_comb begin
        sif.req = sif.pend & sif.en & {N{sif.glb}};
        for (int i = 0; i < N; i++) begin
            sif.lvl[i] = {sif.hi[i], sif.lo[i]};
        end
    end
    // ==========================================
    // winner: highest level, then lowest polling index
    always_comb begin
        sif.any = 1'b0;
        sif.win_id = '0;
        sif.win_lvl = 2'h0;
        for (int i = 0; i < N; i++) begin
            // strict compare keeps the earlier source on equal level
            if (sif.req[i] && (!sif.any || sif.lvl[i] > sif.win_lvl)) begin
                sif.any = 1'b1;
                sif.win_id = IW'(i);
                sif.win_lvl = sif.lvl[i];
            end
        end
    end
endmodule

// ### logic/irq_bank.sv
// interrupt enable and four-level priority bank with pre-emption tracking
// assumes the core writes registers synchronously and pulses ack on handler
// entry and ret on handler return
`timescale 1ns/10ps
module irq_bank
    import irq_bank_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic bit_wr,
    input wire logic bit_rd,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    output logic bit_rdata,
    input wire logic [NUM_SRC-1:0] irq_pend,
    input wire logic irq_ack,
    input wire logic irq_ret,
    output logic irq_req,
    output logic [ID_W-1:0] irq_id,
    output logic [LVL_W-1:0] irq_lvl
);
    logic [7:0] en0_q, en0_d, en1_q, en1_d, ph0_q, ph0_d, pl0_q, pl0_d, pl1_q, pl1_d;
    logic [7:0] rdata_q, rdata_d;
    logic bit_rdata_q, bit_rdata_d;
    logic [3:0] isr_q, isr_d;
    logic req_q, req_d;
    logic [ID_W-1:0] id_q, id_d;
    logic [LVL_W-1:0] lvl_q, lvl_d;
    logic [LVL_W-1:0] cur_lvl;
    logic [LVL_W-1:0] nxt_lvl;
    logic [7:0] bit_mask;
    logic [7:0] bit_reg;

    src_if #(.N(NUM_SRC), .IW(ID_W)) sif ();

    irq_arbiter #(.N(NUM_SRC), .IW(ID_W)) u_arb (
        .sif(sif)
    );

    // ==========================================
    // register map onto polling order
    assign sif.glb = en0_q[GLOBAL_EN_BIT];
    assign sif.pend = irq_pend;
    assign sif.en = {en1_q[3:0], en0_q[5], en0_q[4], en0_q[6], en0_q[3:0]};
    assign sif.lo = {pl1_q[3:0], pl0_q[5], pl0_q[4], pl0_q[6], pl0_q[3:0]};
    // high bits of the second group live outside this bank; they read as zero
    assign sif.hi = {4'h0, ph0_q[5], ph0_q[4], ph0_q[6], ph0_q[3:0]};

    // ==========================================
    // register writes, byte and bit
    always_comb begin
        bit_mask = 8'h01 << bit_addr[BIT_IDX_W-1:0];
        en0_d = en0_q;
        en1_d = en1_q;
        ph0_d = ph0_q;
        pl0_d = pl0_q;
        pl1_d = pl1_q;
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_IRQ_EN0: en0_d = sfr_wdata & MASK_EN0;
                ADDR_IRQ_EN1: en1_d = sfr_wdata & MASK_REG1;
                ADDR_PRIO_HI0: ph0_d = sfr_wdata & MASK_REG0;
                ADDR_PRIO_LO0: pl0_d = sfr_wdata & MASK_REG0;
                ADDR_PRIO_LO1: pl1_d = sfr_wdata & MASK_REG1;
                default: ;
            endcase
        end else if (bit_wr) begin
            case ({bit_addr[7:BIT_IDX_W], 3'h0})
                ADDR_IRQ_EN0: en0_d = (bit_wdata ? en0_q | bit_mask : en0_q & ~bit_mask) & MASK_EN0;
                ADDR_IRQ_EN1: en1_d = (bit_wdata ? en1_q | bit_mask : en1_q & ~bit_mask) & MASK_REG1;
                ADDR_PRIO_LO0: pl0_d = (bit_wdata ? pl0_q | bit_mask : pl0_q & ~bit_mask) & MASK_REG0;
                ADDR_PRIO_LO1: pl1_d = (bit_wdata ? pl1_q | bit_mask : pl1_q & ~bit_mask) & MASK_REG1;
                default: ;
            endcase
        end
    end

    // ==========================================
    // register reads; unused bits and unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        bit_rdata_d = bit_rdata_q;
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_IRQ_EN0: rdata_d = en0_q;
                ADDR_IRQ_EN1: rdata_d = en1_q;
                ADDR_PRIO_HI0: rdata_d = ph0_q;
                ADDR_PRIO_LO0: rdata_d = pl0_q;
                ADDR_PRIO_LO1: rdata_d = pl1_q;
                default: rdata_d = RST_BYTE;
            endcase
        end
        case ({bit_addr[7:BIT_IDX_W], 3'h0})
            ADDR_IRQ_EN0: bit_reg = en0_q;
            ADDR_IRQ_EN1: bit_reg = en1_q;
            ADDR_PRIO_LO0: bit_reg = pl0_q;
            ADDR_PRIO_LO1: bit_reg = pl1_q;
            default: bit_reg = RST_BYTE;
        endcase
        if (bit_rd) begin
            bit_rdata_d = bit_reg[bit_addr[BIT_IDX_W-1:0]];
        end
    end

    // ==========================================
    // in-service levels and request presentation
    always_comb begin
        cur_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (isr_q[l]) begin
                cur_lvl = LVL_W'(l);
            end
        end
        isr_d = isr_q;
        // return retires the running (highest) level before a new entry is noted
        if (irq_ret) begin
            isr_d[cur_lvl] = 1'b0;
        end
        if (irq_ack && req_q) begin
            isr_d[lvl_q] = 1'b1;
        end
        // judged against the next in-service state, so an entered handler drops on the same edge that notes its entry
        nxt_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (isr_d[l]) begin
                nxt_lvl = LVL_W'(l);
            end
        end
        // recomputed every cycle so a withdrawn request drops on the next edge
        req_d = sif.any && (isr_d == RST_ISR || sif.win_lvl > nxt_lvl);
        id_d = sif.win_id;
        lvl_d = sif.win_lvl;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en0_q <= RST_BYTE;
            en1_q <= RST_BYTE;
            ph0_q <= RST_BYTE;
            pl0_q <= RST_BYTE;
            pl1_q <= RST_BYTE;
            rdata_q <= RST_BYTE;
            bit_rdata_q <= 1'b0;
            isr_q <= RST_ISR;
            req_q <= 1'b0;
            id_q <= '0;
            lvl_q <= '0;
        end else begin
            en0_q <= en0_d;
            en1_q <= en1_d;
            ph0_q <= ph0_d;
            pl0_q <= pl0_d;
            pl1_q <= pl1_d;
            rdata_q <= rdata_d;
            bit_rdata_q <= bit_rdata_d;
            isr_q <= isr_d;
            req_q <= req_d;
            id_q <= id_d;
            lvl_q <= lvl_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign bit_rdata = bit_rdata_q;
    assign irq_req = req_q;
    assign irq_id = id_q;
    assign irq_lvl = lvl_q;

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_GLOBAL_OFF: assert property (!en0_q[GLOBAL_EN_BIT] |=> !irq_req)
        else $error("request passed with global enable off");
    AST_SRC_ENABLED: assert property (irq_req
        |-> |($past(sif.en) & (NUM_SRC'(1) << irq_id)) && $past(sif.glb))
        else $error("request from a disabled source");
    AST_EN0_WRITE: assert property (sfr_wr && sfr_addr == ADDR_IRQ_EN0 |=> en0_q == $past(sfr_wdata))
        else $error("enable register 0 did not take the byte");
    AST_EN1_MAP: assert property (sfr_wr && sfr_addr == ADDR_IRQ_EN1 |=> sif.en[10:7] == $past(sfr_wdata[3:0]))
        else $error("enable register 1 bits misplaced");
    AST_PRIO_WRITE: assert property (sfr_wr && sfr_addr == ADDR_PRIO_HI0 |=> ph0_q == ($past(sfr_wdata) & MASK_REG0))
        else $error("priority-high register 0 write wrong");
    AST_PL1_MAP: assert property (sfr_wr && sfr_addr == ADDR_PRIO_LO1 |=> sif.lo[10:7] == $past(sfr_wdata[3:0]))
        else $error("priority-low register 1 bits misplaced");
    AST_PL0_MAP: assert property (sfr_wr && sfr_addr == ADDR_PRIO_LO0 |=> sif.lo[4] == $past(sfr_wdata[6]))
        else $error("counter array low priority bit misplaced");
    AST_BIT_SET: assert property (!sfr_wr && bit_wr && bit_wdata && bit_addr == (ADDR_IRQ_EN1 + 8'h02)
        |=> en1_q[2] && $stable(en1_q[1:0]))
        else $error("single-bit set did not land alone");
    AST_LEVEL: assert property (irq_req |-> irq_lvl ==
        {|($past(sif.hi) & (NUM_SRC'(1) << irq_id)), |($past(sif.lo) & (NUM_SRC'(1) << irq_id))})
        else $error("presented level differs from source level");
    AST_NO_PREEMPT: assert property (irq_req && isr_q != RST_ISR |-> irq_lvl > cur_lvl)
        else $error("equal or lower level pre-empted a handler");
    AST_TOP_LOCK: assert property (isr_q[LVL_TOP] |-> !irq_req)
        else $error("top-level handler pre-empted");
    AST_POLL_FIRST: assert property (irq_req && $past(sif.req[SRC_EXT0]) && $past(sif.lvl[SRC_EXT0]) == irq_lvl
        |-> irq_id == SRC_EXT0)
        else $error("polling order not honoured");
    AST_NO_PEND: assert property ($past(sif.req) == '0 |-> !irq_req)
        else $error("request without effective source");

    COV_TOP_REQ: cover property (irq_req && irq_lvl == LVL_TOP);
    COV_PREEMPT: cover property (irq_req && isr_q != RST_ISR);
    COV_SPI_WIN: cover property (irq_req && irq_id == SRC_SPI);
endmodule

// ### shared/irq_bank_pkg.sv
// constants of the interrupt enable and priority bank
// assumes an 8-bit special-function register space with byte and bit access
package irq_bank_pkg;
    // ==========================================
    // register addresses
    localparam logic [7:0] ADDR_IRQ_EN0 = 8'ha8;
    localparam logic [7:0] ADDR_PRIO_HI0 = 8'hb7;
    localparam logic [7:0] ADDR_PRIO_LO0 = 8'hb8;
    localparam logic [7:0] ADDR_IRQ_EN1 = 8'he8;
    localparam logic [7:0] ADDR_PRIO_LO1 = 8'hf8;
    // ==========================================
    // writable bits and reset values
    localparam logic [7:0] MASK_EN0 = 8'hff;
    localparam logic [7:0] MASK_REG0 = 8'h7f;
    localparam logic [7:0] MASK_REG1 = 8'h0f;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_ISR = 4'h0;
    // ==========================================
    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int BIT_IDX_W = 3;
    // ==========================================
    // sources, in fixed polling order (index 0 polled first)
    localparam int NUM_SRC = 11;
    localparam int ID_W = 4;
    localparam int LVL_W = 2;
    localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
    localparam logic [ID_W-1:0] SRC_EXT0 = 4'h0;
    localparam logic [ID_W-1:0] SRC_SPI = 4'ha;
endpackage

// ### shared/src_if.sv
// per-source request vectors between the register bank and its arbiter
// assumes one clock domain; everything here is combinational
`timescale 1ns/10ps
interface src_if #(parameter int N = 11, parameter int IW = 4) ();
    logic glb;
    logic [N-1:0] pend;
    logic [N-1:0] en;
    logic [N-1:0] hi;
    logic [N-1:0] lo;
    logic [N-1:0] req;
    logic [N-1:0][1:0] lvl;
    logic any;
    logic [IW-1:0] win_id;
    logic [1:0] win_lvl;
    modport bank (output glb, pend, en, hi, lo, input req, lvl, any, win_id, win_lvl);
    modport arb (input glb, pend, en, hi, lo, output req, lvl, any, win_id, win_lvl);
endinterface

// ### verif/core_model.sv
// behavioural core: enters each presented handler and returns after a delay
// assumes the bank samples ack and ret on the rising edge of sys_clk
`timescale 1ns/10ps
module core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic auto_on,
    input wire logic [7:0] hold,
    input wire logic irq_req,
    output logic irq_ack,
    output logic irq_ret
);
    // ==========================================
    // handler entry and return
    logic [3:0] depth;
    logic [7:0] timer;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'b0;
            irq_ret <= 1'b0;
            depth <= 4'h0;
            timer <= 8'h00;
        end else begin
            // single-cycle ack, only while a request is shown
            irq_ack <= auto_on && irq_req && !irq_ack;
            irq_ret <= 1'b0;
            // an ack counts only while a request stands, as the bank notes it
            if (irq_ack && irq_req) begin
                depth <= depth + 4'h1;
                timer <= hold;
            end else if (depth != 4'h0) begin
                if (timer == 8'h00) begin
                    irq_ret <= 1'b1;
                    depth <= depth - 4'h1;
                    timer <= hold;
                end else begin
                    timer <= timer - 8'h01;
                end
            end
        end
    end
endmodule

// ### verif/interrupt_enable_priority_bank_tb.sv
// self-checking bench for the interrupt enable and priority bank
// assumes core_model answers the interrupt side; registers reached by byte and bit strobes
`timescale 1ns/10ps
module interrupt_enable_priority_bank_tb import irq_bank_pkg::*;;
    // ==========================================
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_rd = 1'b0, bit_wdata = 1'b0, auto_on = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, hold = 8'h28;
    logic [NUM_SRC-1:0] irq_pend = '0;
    logic [7:0] sfr_rdata;
    logic bit_rdata, irq_ack, irq_ret, irq_req;
    logic [ID_W-1:0] irq_id;
    logic [LVL_W-1:0] irq_lvl;
    int err_total = 0;
    int comparisons = 0;
    // enable bit address per source in polling order; low priority bit sits 10h above
    localparam logic [7:0] EN_BIT [NUM_SRC] = '{8'ha8, 8'ha9, 8'haa, 8'hab, 8'hae, 8'hac, 8'had,
        8'he8, 8'he9, 8'hea, 8'heb};
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_s;
    // unused upper bits always written as zero
    localparam row_s ROWS [8] = '{'{8'ha8, 8'hff, 8'hff}, '{8'hb7, 8'h7f, 8'h7f}, '{8'hb8, 8'h7f, 8'h7f},
        '{8'he8, 8'h0f, 8'h0f}, '{8'hf8, 8'h0f, 8'h0f}, '{8'ha8, 8'h2a, 8'h2a}, '{8'hb7, 8'h55, 8'h55},
        '{8'h3c, 8'h0f, 8'h00}};
    irq_bank dut (.sys_clk, .rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .bit_wr, .bit_rd,
        .bit_addr, .bit_wdata, .bit_rdata, .irq_pend, .irq_ack, .irq_ret, .irq_req, .irq_id, .irq_lvl);
    core_model partner (.sys_clk, .rst, .auto_on, .hold, .irq_req, .irq_ack, .irq_ret);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ==========================================
    // shared tasks
    task automatic complete_run();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(negedge sys_clk);
        chk("sfr_rdata", exp, sfr_rdata);
        @(posedge sys_clk);
    endtask
    task automatic bwr(logic [7:0] a, logic v);
        bit_addr <= a;
        bit_wdata <= v;
        bit_wr <= 1'b1;
        @(posedge sys_clk);
        bit_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic brd(logic [7:0] a, logic exp);
        bit_addr <= a;
        bit_rd <= 1'b1;
        @(posedge sys_clk);
        bit_rd <= 1'b0;
        @(negedge sys_clk);
        chk("bit_rdata", {7'h00, exp}, {7'h00, bit_rdata});
        @(posedge sys_clk);
    endtask
    // request outputs settle one edge after their cause; a missing request ends the run
    task automatic see(logic r, logic [3:0] id, logic [1:0] lv);
        int n;
        repeat (2) @(negedge sys_clk);
        for (n = 0; n < (r ? 60 : 8) && !(r && irq_req === 1'b1); n++) begin
            @(negedge sys_clk);
        end
        chk("irq_req", {7'h00, r}, {7'h00, irq_req});
        if (r) begin
            chk("irq_id", {4'h0, id}, {4'h0, irq_id});
            chk("irq_lvl", {6'h00, lv}, {6'h00, irq_lvl});
            if (irq_req !== 1'b1) complete_run();
        end
        @(posedge sys_clk);
    endtask
    // ==========================================
    // main sequence
    initial begin
        int i;
        logic [7:0] a;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (ROWS[k]) rd(ROWS[k].addr, 8'h00);
        foreach (ROWS[k]) begin
            wr(ROWS[k].addr, ROWS[k].wdata);
            rd(ROWS[k].addr, ROWS[k].rdata);
        end
        bwr(8'had, 1'b0);
        rd(8'ha8, 8'h0a);
        brd(8'had, 1'b0);
        brd(8'ha9, 1'b1);
        brd(8'hbe, 1'b1);
        bwr(8'hfb, 1'b0);
        rd(8'hf8, 8'h07);
        brd(8'hfa, 1'b1);
        bwr(8'hb7, 1'b1);
        rd(8'hb7, 8'h55);
        for (i = 0; i < 5; i++) wr(ROWS[i].addr, 8'h00);
        bwr(8'haf, 1'b1);
        for (i = 0; i < NUM_SRC; i++) begin
            a = EN_BIT[i];
            irq_pend <= NUM_SRC'(1) << i;
            bwr(a, 1'b1);
            see(1'b1, 4'(i), 2'h0);
            bwr(8'haf, 1'b0);
            see(1'b0, 4'h0, 2'h0);
            bwr(8'haf, 1'b1);
            bwr(a + 8'h10, 1'b1);
            see(1'b1, 4'(i), 2'h1);
            bwr(a + 8'h10, 1'b0);
            bwr(a, 1'b0);
            see(1'b0, 4'h0, 2'h0);
        end
        wr(8'ha8, 8'hff);
        wr(8'he8, 8'h0f);
        for (i = 0; i < NUM_SRC; i++) begin
            irq_pend <= {NUM_SRC{1'b1}} << i;
            see(1'b1, 4'(i), 2'h0);
        end
        irq_pend <= {NUM_SRC{1'b1}};
        wr(8'hf8, 8'h08);
        wr(8'hb7, 8'h40);
        see(1'b1, 4'h4, 2'h2);
        wr(8'hb8, 8'h40);
        see(1'b1, 4'h4, 2'h3);
        wr(8'hb7, 8'h00);
        wr(8'hb8, 8'h00);
        // the core now enters handlers; pending stays high to probe the refusals
        auto_on <= 1'b1;
        irq_pend <= 11'h021;
        see(1'b1, 4'h0, 2'h0);
        see(1'b0, 4'h0, 2'h0);
        // counter array joins at level 0 and stays blocked until raised
        irq_pend <= 11'h431;
        see(1'b1, 4'ha, 2'h1);
        wr(8'hb8, 8'h40);
        wr(8'hb7, 8'h40);
        see(1'b1, 4'h4, 2'h3);
        wr(8'hb8, 8'h42);
        wr(8'hb7, 8'h42);
        irq_pend <= 11'h433;
        see(1'b0, 4'h0, 2'h0);
        see(1'b1, 4'h1, 2'h3);
        // mid-run reset: registers and request fall back to idle
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (i = 0; i < 5; i++) rd(ROWS[i].addr, 8'h00);
        see(1'b0, 4'h0, 2'h0);
        complete_run();
    end
endmodule
